/* File: rtl/pio_pkg.sv */
// Constants shared by the three-port parallel I/O block
`default_nettype none

package pio_pkg;

  // Register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Port widths
  localparam int FIRST_W  = 7;
  localparam int SECOND_W = 8;
  localparam int THIRD_W  = 8;

  // Register offsets, at the printed addresses
  localparam logic [3:0] OFS_FIRST_DATA  = 4'h0;
  localparam logic [3:0] OFS_SECOND_DATA = 4'h1;
  localparam logic [3:0] OFS_THIRD_DATA  = 4'h2;
  localparam logic [3:0] OFS_FIRST_DIR   = 4'h4;
  localparam logic [3:0] OFS_SECOND_DIR  = 4'h5;
  localparam logic [3:0] OFS_THIRD_DIR   = 4'h6;

  // Event status, event mask and live level registers
  localparam logic [3:0] OFS_EVT_STATUS  = 4'h8;
  localparam logic [3:0] OFS_EVT_MASK    = 4'h9;
  localparam logic [3:0] OFS_LEVELS      = 4'ha;

  // Event status and mask bit positions
  localparam int EVT_THIRD_EDGE = 0;
  localparam int EVT_PIN_EDGE   = 1;
  localparam int EVT_W          = 2;

  // Live level register bit positions
  localparam int LVL_INT_PIN  = 0;
  localparam int LVL_CPU_IRQ  = 1;
  localparam int LVL_THIRD_RQ = 2;
  localparam int LVL_PIN_RQ   = 3;

  // Reset values
  localparam logic [FIRST_W-1:0]  FIRST_DIR_RST  = 7'h00;
  localparam logic [SECOND_W-1:0] SECOND_DIR_RST = 8'h00;
  localparam logic [THIRD_W-1:0]  THIRD_DIR_RST  = 8'h00;
  localparam logic [EVT_W-1:0]    EVT_MASK_RST   = 2'h0;
  localparam logic [EVT_W-1:0]    EVT_STAT_RST   = 2'h0;
  localparam logic [DATA_W-1:0]   RDATA_RST      = 8'h00;

endpackage

`default_nettype wire

/* File: rtl/pio_ports.sv */
// Three parallel I/O ports with edge interrupt on the third port
// Functional notes
// RQ1: Seven-pin first port, data 0, direction 4
// RQ2: Eight-pin second port, data 1, direction 5
// RQ3: Eight-pin third port, data 2, direction 6
// RQ4: Direction one is output, zero is input
// RQ5: Output pins drive their data register bit
// RQ6: Input pins read back live pin level
// RQ7: Reset clears directions, keeps data registers
// RQ8: Third-port pins ANDed into CPU interrupt input
// RQ9: Third port has its own request latch
// RQ10: Only falling edges set the third-port request
// RQ11: Pin interrupt needs direction and data zero
// RQ12: Output pins falling never raise port interrupt
// RQ13: Second port shared with PWM, timer, SPI
// RQ14: Pin level status reflects dedicated pin only
// RQ15: Software takes care writing third-port registers
// RQ16: Request latch holds until acknowledge, reset clears
`timescale 1ns/1ps
`default_nettype none

module pio_ports #(
  parameter int FIRST_W  = pio_pkg::FIRST_W,
  parameter int SECOND_W = pio_pkg::SECOND_W,
  parameter int THIRD_W  = pio_pkg::THIRD_W
) (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic [pio_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [pio_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [pio_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic [FIRST_W-1:0]          first_port_in,
  output logic      [FIRST_W-1:0]          first_port_out,
  output logic      [FIRST_W-1:0]          first_port_oe,
  input  wire logic [SECOND_W-1:0]         second_port_in,
  output logic      [SECOND_W-1:0]         second_port_out,
  output logic      [SECOND_W-1:0]         second_port_oe,
  input  wire logic [SECOND_W-1:0]         second_alt_en,
  input  wire logic [SECOND_W-1:0]         second_alt_out,
  input  wire logic [SECOND_W-1:0]         second_alt_oe,
  input  wire logic [THIRD_W-1:0]          third_port_in,
  output logic      [THIRD_W-1:0]          third_port_out,
  output logic      [THIRD_W-1:0]          third_port_oe,
  input  wire logic                        int_pin_n,
  input  wire logic                        third_req_ack,
  input  wire logic                        pin_req_ack,
  output logic                             cpu_irq_n,
  output logic                             third_req,
  output logic                             pin_req,
  output logic                             int_pin_high,
  output logic                             irq
);

  // Port registers; data registers carry no reset on purpose
  logic [FIRST_W-1:0]  first_port_data;
  logic [FIRST_W-1:0]  first_port_direction;
  logic [SECOND_W-1:0] second_port_data;
  logic [SECOND_W-1:0] second_port_direction;
  logic [THIRD_W-1:0]  third_port_data;
  logic [THIRD_W-1:0]  third_port_direction;

  // Event registers
  logic [pio_pkg::EVT_W-1:0] evt_status;
  logic [pio_pkg::EVT_W-1:0] evt_mask;
  logic [pio_pkg::EVT_W-1:0] next_evt_status;

  // Edge detection state
  logic                prev_valid;
  logic                prev_wired;
  logic                prev_int_pin;
  logic [THIRD_W-1:0]  third_src_en;
  logic                third_wired;
  logic                third_fall;
  logic                pin_fall;

  // Decoded strobes
  logic wr_first_data;
  logic wr_second_data;
  logic wr_third_data;
  logic wr_first_dir;
  logic wr_second_dir;
  logic wr_third_dir;
  logic wr_status;
  logic wr_mask;

  // Mix stored data and live pins: outputs read data, inputs read pins
  function automatic logic [pio_pkg::DATA_W-1:0] mix_read(
    input logic [pio_pkg::DATA_W-1:0] dir,
    input logic [pio_pkg::DATA_W-1:0] data,
    input logic [pio_pkg::DATA_W-1:0] pins
  );
    mix_read = (dir & data) | (~dir & pins);
  endfunction

  // Address decode for writes
  always_comb begin
    wr_first_data  = reg_wr && (reg_addr == pio_pkg::OFS_FIRST_DATA);  // RQ1
    wr_second_data = reg_wr && (reg_addr == pio_pkg::OFS_SECOND_DATA); // RQ2
    wr_third_data  = reg_wr && (reg_addr == pio_pkg::OFS_THIRD_DATA);  // RQ3
    wr_first_dir   = reg_wr && (reg_addr == pio_pkg::OFS_FIRST_DIR);   // RQ1
    wr_second_dir  = reg_wr && (reg_addr == pio_pkg::OFS_SECOND_DIR);  // RQ2
    wr_third_dir   = reg_wr && (reg_addr == pio_pkg::OFS_THIRD_DIR);   // RQ3
    wr_status      = reg_wr && (reg_addr == pio_pkg::OFS_EVT_STATUS);
    wr_mask        = reg_wr && (reg_addr == pio_pkg::OFS_EVT_MASK);
  end

  // Data registers keep their contents through reset
  always_ff @(posedge ref_clk) begin
    if (wr_first_data) begin
      first_port_data <= reg_wdata[FIRST_W-1:0]; // RQ7
    end
    if (wr_second_data) begin
      second_port_data <= reg_wdata[SECOND_W-1:0];
    end
    if (wr_third_data) begin
      third_port_data <= reg_wdata[THIRD_W-1:0];
    end
  end

  // Direction registers come up all inputs
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      first_port_direction  <= pio_pkg::FIRST_DIR_RST;  // RQ7
      second_port_direction <= pio_pkg::SECOND_DIR_RST; // RQ7
      third_port_direction  <= pio_pkg::THIRD_DIR_RST;  // RQ7
    end else begin
      if (wr_first_dir) begin
        first_port_direction <= reg_wdata[FIRST_W-1:0];
      end
      if (wr_second_dir) begin
        second_port_direction <= reg_wdata[SECOND_W-1:0];
      end
      if (wr_third_dir) begin
        third_port_direction <= reg_wdata[THIRD_W-1:0];
      end
    end
  end

  // Pin drivers: a set direction bit enables the driver
  always_comb begin
    first_port_oe  = first_port_direction;  // RQ4
    first_port_out = first_port_data;       // RQ5
    third_port_oe  = third_port_direction;  // RQ4
    third_port_out = third_port_data;       // RQ5
  end

  // Second port: a unit that claims a pin takes over its driver
  always_comb begin
    second_port_oe  = (second_alt_en & second_alt_oe)
                    | (~second_alt_en & second_port_direction);  // RQ13
    second_port_out = (second_alt_en & second_alt_out)
                    | (~second_alt_en & second_port_data);       // RQ13
  end

  // Only input pins with a clear data bit join the wired line
  always_comb begin
    third_src_en = ~third_port_direction & ~third_port_data; // RQ11
    third_wired  = &(third_port_in | ~third_src_en);         // RQ8 RQ12
    cpu_irq_n    = int_pin_n & third_wired;                  // RQ8
  end

  // Previous levels; first cycle after reset only primes them
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_valid   <= 1'b0;
      prev_wired   <= 1'b1;
      prev_int_pin <= 1'b1;
    end else begin
      prev_valid   <= 1'b1;
      prev_wired   <= third_wired;
      prev_int_pin <= int_pin_n;
    end
  end

  // Falling edges only; a pin rising or held low sets nothing
  always_comb begin
    third_fall = prev_valid && prev_wired && !third_wired; // RQ10
    pin_fall   = prev_valid && prev_int_pin && !int_pin_n;
  end

  // Third-port request latch, separate from the pin latch
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      third_req <= 1'b0; // RQ16
    end else if (third_fall) begin
      third_req <= 1'b1; // RQ9 RQ10
    end else if (third_req_ack) begin
      third_req <= 1'b0; // RQ16
    end
  end

  // Dedicated pin request latch; a new edge beats the acknowledge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_req <= 1'b0;
    end else if (pin_fall) begin
      pin_req <= 1'b1; // RQ9
    end else if (pin_req_ack) begin
      pin_req <= 1'b0;
    end
  end

  // Branch tests see the dedicated pin, never the wired line
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      int_pin_high <= 1'b1;
    end else begin
      int_pin_high <= int_pin_n; // RQ14
    end
  end

  // Sticky event bits, write one to clear, set wins over clear
  always_comb begin
    next_evt_status = evt_status;
    if (wr_status) begin
      next_evt_status = evt_status & ~reg_wdata[pio_pkg::EVT_W-1:0];
    end
    if (third_fall) begin
      next_evt_status[pio_pkg::EVT_THIRD_EDGE] = 1'b1;
    end
    if (pin_fall) begin
      next_evt_status[pio_pkg::EVT_PIN_EDGE] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evt_status <= pio_pkg::EVT_STAT_RST;
    end else begin
      evt_status <= next_evt_status;
    end
  end

  // Mask register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evt_mask <= pio_pkg::EVT_MASK_RST;
    end else if (wr_mask) begin
      evt_mask <= reg_wdata[pio_pkg::EVT_W-1:0];
    end
  end

  // Level interrupt, high while an unmasked event is pending
  always_comb begin
    irq = |(evt_status & evt_mask);
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= pio_pkg::RDATA_RST;
    end else begin
      case (reg_addr)
        pio_pkg::OFS_FIRST_DATA: begin
          reg_rdata <= mix_read({1'b0, first_port_direction},
                                {1'b0, first_port_data},
                                {1'b0, first_port_in}); // RQ6
        end
        pio_pkg::OFS_SECOND_DATA: begin
          reg_rdata <= mix_read(second_port_direction, second_port_data,
                                second_port_in); // RQ6
        end
        pio_pkg::OFS_THIRD_DATA: begin
          reg_rdata <= mix_read(third_port_direction, third_port_data,
                                third_port_in); // RQ6
        end
        pio_pkg::OFS_FIRST_DIR: begin
          reg_rdata <= {1'b0, first_port_direction};
        end
        pio_pkg::OFS_SECOND_DIR: begin
          reg_rdata <= second_port_direction;
        end
        pio_pkg::OFS_THIRD_DIR: begin
          reg_rdata <= third_port_direction;
        end
        pio_pkg::OFS_EVT_STATUS: begin
          reg_rdata <= {6'h00, evt_status};
        end
        pio_pkg::OFS_EVT_MASK: begin
          reg_rdata <= {6'h00, evt_mask};
        end
        pio_pkg::OFS_LEVELS: begin
          reg_rdata <= {4'h0, pin_req, third_req, cpu_irq_n,
                        int_pin_high}; // RQ14
        end
        default: begin
          reg_rdata <= pio_pkg::RDATA_RST;
        end
      endcase
    end
  end

  // Direction cleared at the first edge after reset
  dir_reset_a: assert property ( // RQ7
    @(posedge ref_clk) srst |=> (first_port_oe == 7'h00)
      && (third_port_oe == 8'h00)
      && ((second_port_oe & ~second_alt_en) == 8'h00))
    else $error("direction not cleared by reset");

  // A direction write shows on the enables one cycle later
  dir_write_a: assert property ( // RQ4
    @(posedge ref_clk) disable iff (srst)
      (reg_wr && reg_addr == pio_pkg::OFS_THIRD_DIR)
      |=> third_port_oe == $past(reg_wdata))
    else $error("third port enables do not follow direction write");

  // A data write shows on output pins one cycle later
  out_data_a: assert property ( // RQ5
    @(posedge ref_clk) disable iff (srst)
      (reg_wr && reg_addr == pio_pkg::OFS_FIRST_DATA)
      |=> first_port_out == $past(reg_wdata[6:0]))
    else $error("first port output does not follow data write");

  // Input pins read back as the pins stood at the strobe
  pin_read_a: assert property ( // RQ6
    @(posedge ref_clk) disable iff (srst)
      (reg_rd && reg_addr == pio_pkg::OFS_SECOND_DATA
        && second_port_direction == 8'h00)
      |=> reg_rdata == $past(second_port_in))
    else $error("second port read does not show pin levels");

  // Any enabled low pin pulls the CPU line low
  wired_and_a: assert property ( // RQ8
    @(posedge ref_clk) disable iff (srst)
      ((third_src_en & ~third_port_in) != 8'h00) |-> !cpu_irq_n)
    else $error("enabled low pin did not pull CPU line");

  // Port request rises only after a fall of enabled pins
  edge_only_a: assert property ( // RQ10
    @(posedge ref_clk) disable iff (srst)
      $rose(third_req) |-> $past(prev_wired) && !$past(third_wired))
    else $error("port request set without a falling edge");

  // No source enabled means no new port request
  gate_en_a: assert property ( // RQ11
    @(posedge ref_clk) disable iff (srst)
      $rose(third_req) |-> $past(third_src_en) != 8'h00)
    else $error("port request from disabled pins");

  // Output pins swinging low keep the wired line high, so nothing sets
  out_quiet_a: assert property ( // RQ12
    @(posedge ref_clk) disable iff (srst)
      (!third_req && third_wired) |=> !third_req)
    else $error("output pins raised port request");

  // Latch holds until the acknowledge
  req_hold_a: assert property ( // RQ16
    @(posedge ref_clk) disable iff (srst)
      third_req && !third_req_ack |=> third_req)
    else $error("port request dropped without acknowledge");

  // Pin latch rises only from the dedicated pin
  latch_apart_a: assert property ( // RQ9
    @(posedge ref_clk) disable iff (srst)
      $rose(pin_req) |-> $past(pin_fall))
    else $error("pin latch set by another source");

  // Branch level tracks the pin alone, one cycle late
  pin_level_a: assert property ( // RQ14
    @(posedge ref_clk) disable iff (srst)
      !$past(srst) |-> int_pin_high == $past(int_pin_n))
    else $error("branch level does not follow the pin");

  // A claimed second-port pin takes its enable from the shared unit
  alt_take_a: assert property ( // RQ13
    @(posedge ref_clk) disable iff (srst)
      ((second_port_oe ^ second_alt_oe) & second_alt_en) == 8'h00)
    else $error("shared unit did not take the second port pin");

endmodule

`default_nettype wire

/* File: dv/pio_board.sv */
// Board-side model of the pins attached to the three ports
`timescale 1ns/1ps
`default_nettype none

module pio_board (
  input  wire logic [6:0] a_out,
  input  wire logic [6:0] a_oe,
  input  wire logic [6:0] a_ext,
  output logic      [6:0] a_pin,
  input  wire logic [7:0] b_out,
  input  wire logic [7:0] b_oe,
  input  wire logic [7:0] b_ext,
  output logic      [7:0] b_pin,
  input  wire logic [7:0] c_out,
  input  wire logic [7:0] c_oe,
  input  wire logic [7:0] c_ext,
  output logic      [7:0] c_pin
);
  // A driven pin shows the port's level, otherwise the board's level
  assign a_pin = (a_oe & a_out) | (~a_oe & a_ext);
  assign b_pin = (b_oe & b_out) | (~b_oe & b_ext);
  assign c_pin = (c_oe & c_out) | (~c_oe & c_ext);
endmodule

`default_nettype wire

/* File: dv/test_pio_ports.sv */
// Register and pin tests of the three-port parallel I/O block
`timescale 1ns/1ps
`default_nettype none

module test_pio_ports;
  logic       ref_clk, srst, reg_wr, reg_rd, int_pin_n;
  logic       third_req_ack, pin_req_ack;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [6:0] a_in, a_out, a_oe, a_ext;
  logic [7:0] b_in, b_out, b_oe, b_ext, alt_en, alt_out, alt_oe;
  logic [7:0] c_in, c_out, c_oe, c_ext;
  logic       cpu_irq_n, third_req, pin_req, int_pin_high, irq;
  int         miscompares, checks;

  pio_ports dut_u (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .first_port_in(a_in), .first_port_out(a_out),
    .first_port_oe(a_oe), .second_port_in(b_in), .second_port_out(b_out),
    .second_port_oe(b_oe), .second_alt_en(alt_en),
    .second_alt_out(alt_out), .second_alt_oe(alt_oe),
    .third_port_in(c_in), .third_port_out(c_out), .third_port_oe(c_oe),
    .int_pin_n(int_pin_n), .third_req_ack(third_req_ack),
    .pin_req_ack(pin_req_ack), .cpu_irq_n(cpu_irq_n),
    .third_req(third_req), .pin_req(pin_req),
    .int_pin_high(int_pin_high), .irq(irq));

  pio_board board_u (.a_out(a_out), .a_oe(a_oe), .a_ext(a_ext), .a_pin(a_in),
    .b_out(b_out), .b_oe(b_oe), .b_ext(b_ext), .b_pin(b_in),
    .c_out(c_out), .c_oe(c_oe), .c_ext(c_ext), .c_pin(c_in));

  // Free-running 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic results;
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Watchdog well beyond the expected run of about a hundred cycles
  initial begin
    #50000;
    miscompares++;
    results();
  end

  initial begin
    miscompares = 0;
    checks = 0;
    srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 8'h00; int_pin_n = 1'b1; third_req_ack = 1'b0;
    pin_req_ack = 1'b0; a_ext = 7'h2a; b_ext = 8'hc3; c_ext = 8'h3f;
    alt_en = 8'h00; alt_out = 8'h00; alt_oe = 8'h00;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    // Directions come up as inputs
    rd(pio_pkg::OFS_FIRST_DIR, 8'h00);
    rd(pio_pkg::OFS_SECOND_DIR, 8'h00);
    rd(pio_pkg::OFS_THIRD_DIR, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // Data bits on the third port set first, so no pin is enabled
    wr(pio_pkg::OFS_FIRST_DATA, 8'h55);
    wr(pio_pkg::OFS_SECOND_DATA, 8'ha5);
    wr(pio_pkg::OFS_THIRD_DATA, 8'hff);
    wr(pio_pkg::OFS_FIRST_DIR, 8'h7f);
    wr(pio_pkg::OFS_SECOND_DIR, 8'hff);
    wr(pio_pkg::OFS_THIRD_DIR, 8'h0f);
    wait_cyc(1);
    chk({1'b0, a_out}, 8'h55);
    chk({1'b0, a_oe}, 8'h7f);
    chk(b_out, 8'ha5);
    chk(b_oe, 8'hff);
    chk(c_oe, 8'h0f);
    rd(pio_pkg::OFS_FIRST_DATA, 8'h55);
    rd(pio_pkg::OFS_SECOND_DATA, 8'ha5);
    // Upper nibble is input and shows the board level
    rd(pio_pkg::OFS_THIRD_DATA, 8'h3f);
    wr(pio_pkg::OFS_FIRST_DIR, 8'h00);
    rd(pio_pkg::OFS_FIRST_DATA, 8'h2a);
    // Shared units take bits 5:4 of the second port
    @(posedge ref_clk);
    alt_en  <= 8'h30;
    alt_oe  <= 8'h10;
    alt_out <= 8'h10;
    wait_cyc(1);
    chk(b_oe, 8'hdf);
    chk(b_out, 8'h95);
    @(posedge ref_clk);
    alt_en <= 8'h00;
    // Mid-run reset keeps the data registers
    wr(pio_pkg::OFS_FIRST_DIR, 8'h7f);
    c_ext <= 8'hff;
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk({1'b0, a_oe}, 8'h00);
    chk(c_oe, 8'h00);
    chk({1'b0, a_out}, 8'h55);
    chk(b_out, 8'ha5);
    // Second port is all inputs again and reads the board
    rd(pio_pkg::OFS_SECOND_DATA, 8'hc3);
    // Enable all third-port pins while the board holds them high
    wr(pio_pkg::OFS_EVT_MASK, 8'h03);
    rd(pio_pkg::OFS_EVT_MASK, 8'h03);
    wr(pio_pkg::OFS_THIRD_DATA, 8'h00);
    wait_cyc(2);
    chk({7'h00, third_req}, 8'h00);
    @(posedge ref_clk);
    c_ext <= 8'hfe;
    wait_cyc(3);
    chk({7'h00, cpu_irq_n}, 8'h00);
    chk({7'h00, third_req}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, int_pin_high}, 8'h01);
    rd(pio_pkg::OFS_EVT_STATUS, 8'h01);
    rd(pio_pkg::OFS_LEVELS, 8'h05);
    wait_cyc(4);
    chk({7'h00, third_req}, 8'h01);
    // Acknowledge and clear, then a rising edge must not set it
    @(posedge ref_clk);
    third_req_ack <= 1'b1;
    @(posedge ref_clk);
    third_req_ack <= 1'b0;
    wr(pio_pkg::OFS_EVT_STATUS, 8'h01);
    wait_cyc(1);
    chk({7'h00, third_req}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    @(posedge ref_clk);
    c_ext <= 8'hff;
    wait_cyc(3);
    chk({7'h00, third_req}, 8'h00);
    // Data bit set disables pin 0
    wr(pio_pkg::OFS_THIRD_DATA, 8'h01);
    c_ext <= 8'hfe;
    wait_cyc(3);
    chk({7'h00, third_req}, 8'h00);
    chk({7'h00, cpu_irq_n}, 8'h01);
    @(posedge ref_clk);
    c_ext <= 8'hff;
    // Pin 1 as output falling from one to zero
    wr(pio_pkg::OFS_THIRD_DATA, 8'h03);
    wr(pio_pkg::OFS_THIRD_DIR, 8'h02);
    wr(pio_pkg::OFS_THIRD_DATA, 8'h01);
    wait_cyc(3);
    chk({7'h00, c_in[1]}, 8'h00);
    chk(c_out, 8'h01);
    chk({7'h00, third_req}, 8'h00);
    rd(pio_pkg::OFS_EVT_STATUS, 8'h00);
    // Dedicated pin has its own latch; masked it leaves irq low
    wr(pio_pkg::OFS_EVT_MASK, 8'h00);
    int_pin_n <= 1'b0;
    wait_cyc(3);
    chk({7'h00, pin_req}, 8'h01);
    chk({7'h00, third_req}, 8'h00);
    chk({7'h00, int_pin_high}, 8'h00);
    chk({7'h00, cpu_irq_n}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rd(pio_pkg::OFS_EVT_STATUS, 8'h02);
    wr(pio_pkg::OFS_EVT_MASK, 8'h02);
    wait_cyc(1);
    chk({7'h00, irq}, 8'h01);
    @(posedge ref_clk);
    int_pin_n <= 1'b1;
    pin_req_ack <= 1'b1;
    @(posedge ref_clk);
    pin_req_ack <= 1'b0;
    wr(pio_pkg::OFS_EVT_STATUS, 8'h02);
    wait_cyc(1);
    chk({7'h00, pin_req}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // Unmapped places read as zero
    rd(4'h3, 8'h00);
    rd(4'hf, 8'h00);
    results();
  end
endmodule

`default_nettype wire
